// ### adcsq_pkg.sv
//==========================================================
// How it works
// - Reference code maps to supply/external pairs
// - Calibration grounds converter inputs
// - Calibration clear samples selected input normally
// - Calibration ignores pin config and channel select
// - Scan bit steps first mux inputs
// - Interrupt after seq_per_irq plus one sequences
// - Alternate: first mux, then second, first...
// - Alternate clear: always first mux
// - Unimplemented bits ignore writes, read zero
package adcsq_pkg;
   localparam logic [3:0] ADCSQ_OFF_CTRL = 4'h0;
   localparam logic [3:0] ADCSQ_OFF_STAT = 4'h4;
   localparam int ADCSQ_REF_LSB = 13;
   localparam int ADCSQ_CAL_BIT = 12;
   localparam int ADCSQ_SCAN_BIT = 10;
   localparam int ADCSQ_RSV7_BIT = 7;
   localparam int ADCSQ_SEQ_LSB = 2;
   localparam int ADCSQ_RSV1_BIT = 1;
   localparam int ADCSQ_ALT_BIT = 0;
   localparam logic [15:0] ADCSQ_CTRL_RESET = 16'h0000;
   localparam logic [15:0] ADCSQ_WMASK = 16'hf43f;
   // Reference pairs: bit1 = positive from external pin, bit0 = negative from external pin
   localparam logic [1:0] ADCSQ_REF_INT = 2'h0;
   localparam logic [1:0] ADCSQ_REF_EXTP = 2'h2;
   localparam logic [1:0] ADCSQ_REF_EXTN = 2'h1;
   localparam logic [1:0] ADCSQ_REF_BOTH = 2'h3;
   typedef enum logic {ADCSQ_MUX_FIRST, ADCSQ_MUX_SECOND} adcsq_mux_e;
endpackage : adcsq_pkg

// ### adcsq_top.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module adcsq_top
   import adcsq_pkg::*;
#(
   parameter int CH_W = 4
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic conv_active,
   input wire logic sample_done,
   input wire logic seq_done,
   input wire logic [CH_W-1:0] first_mux_ch,
   input wire logic [CH_W-1:0] second_mux_ch,
   input wire logic [CH_W-1:0] scan_ch,
   output logic [1:0] ref_select,
   output logic offset_cal_enable,
   output logic inputs_to_ground,
   output logic input_switch_en,
   output logic scan_first_mux,
   output logic mux_sel,
   output logic [CH_W-1:0] sample_ch,
   output logic irq_pulse
);
   //==========================================================
   // Register file
   //==========================================================
   logic [15:0] ctrl_r, ctrl_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic rsv7_r, rsv7_nxt;
   logic [3:0] seq_cnt_r, seq_cnt_nxt;
   adcsq_mux_e mux_r, mux_nxt;
   logic irq_r, irq_nxt;
   logic [CH_W-1:0] ch_r, ch_nxt;

   function automatic logic [1:0] ref_decode(input logic [2:0] code);
      case (code)
         3'h1: ref_decode = ADCSQ_REF_EXTP;
         3'h2: ref_decode = ADCSQ_REF_EXTN;
         3'h3: ref_decode = ADCSQ_REF_BOTH;
         default: ref_decode = ADCSQ_REF_INT;
      endcase
   endfunction : ref_decode

   wire logic ctrl_wr = reg_wr && (reg_addr == ADCSQ_OFF_CTRL);
   wire logic [3:0] seq_per_irq = ctrl_r[ADCSQ_SEQ_LSB +: 4];
   wire logic scan = ctrl_r[ADCSQ_SCAN_BIT];
   wire logic [2:0] ref_code = ctrl_r[ADCSQ_REF_LSB +: 3];
   // Bits that must read back as zero; bit 7 is left out since software ignores it anyway
   localparam logic [15:0] UNIMPL_MASK = ~ADCSQ_WMASK & ~(16'h0001 << ADCSQ_RSV7_BIT);
   wire logic cal = ctrl_r[ADCSQ_CAL_BIT];
   wire logic alt = ctrl_r[ADCSQ_ALT_BIT];

   always_comb begin
      ctrl_nxt = ctrl_r;
      rdata_nxt = 16'h0000;
      // Bit 7 has no defined content; it simply holds its reset value of zero
      rsv7_nxt = rsv7_r;
      if (ctrl_wr) begin
         ctrl_nxt = reg_wdata & ADCSQ_WMASK;
      end
      if (reg_rd) begin
         case (reg_addr)
            ADCSQ_OFF_CTRL: rdata_nxt = ctrl_r | {8'h00, rsv7_r, 7'h00};
            ADCSQ_OFF_STAT: rdata_nxt = {7'h00, irq_r, 3'h0, mux_r, seq_cnt_r};
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   //==========================================================
   // Sequence counting and mux alternation
   //==========================================================
   always_comb begin
      seq_cnt_nxt = seq_cnt_r;
      irq_nxt = 1'b0;
      mux_nxt = mux_r;
      if (ctrl_wr || !conv_active) begin
         seq_cnt_nxt = 4'h0;
      end else if (seq_done) begin
         // Reserved code 1111 just counts sixteen sequences; nothing guards against it
         if (seq_cnt_r >= seq_per_irq) begin
            seq_cnt_nxt = 4'h0;
            irq_nxt = 1'b1;
         end else begin
            seq_cnt_nxt = seq_cnt_r + 4'h1;
         end
      end
      if (!conv_active || !alt) begin
         mux_nxt = ADCSQ_MUX_FIRST;
      end else if (sample_done) begin
         mux_nxt = (mux_r == ADCSQ_MUX_FIRST) ? ADCSQ_MUX_SECOND : ADCSQ_MUX_FIRST;
      end
   end

   //==========================================================
   // Channel routing
   //==========================================================
   always_comb begin
      if (cal) begin
         ch_nxt = '0;
      end else if (mux_r == ADCSQ_MUX_SECOND) begin
         ch_nxt = second_mux_ch;
      end else if (ctrl_r[ADCSQ_SCAN_BIT]) begin
         ch_nxt = scan_ch;
      end else begin
         ch_nxt = first_mux_ch;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= ADCSQ_CTRL_RESET;
         rdata_r <= 16'h0000;
         rsv7_r <= 1'b0;
         seq_cnt_r <= 4'h0;
         mux_r <= ADCSQ_MUX_FIRST;
         irq_r <= 1'b0;
         ch_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
         rsv7_r <= rsv7_nxt;
         seq_cnt_r <= seq_cnt_nxt;
         mux_r <= mux_nxt;
         irq_r <= irq_nxt;
         ch_r <= ch_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign ref_select = ref_decode(ctrl_r[ADCSQ_REF_LSB +: 3]);
   assign offset_cal_enable = cal;
   assign inputs_to_ground = cal;
   assign input_switch_en = !cal;
   assign scan_first_mux = ctrl_r[ADCSQ_SCAN_BIT] && !cal;
   assign mux_sel = mux_r;
   assign sample_ch = ch_r;
   assign irq_pulse = irq_r;

   //==========================================================
   // Checks
   //==========================================================
   sequence s_seq_ev;
      conv_active && !ctrl_wr && seq_done;
   endsequence

   // A control write while converting restarts the count
   sequence s_restart;
      conv_active && ctrl_wr;
   endsequence

   // Converting, with neither a control write nor a finished sequence
   sequence s_idle;
      conv_active && !ctrl_wr && !seq_done;
   endsequence

   a_irq_every_seq: assert property (@(posedge clk) disable iff (!resetn)
      ((seq_per_irq == 4'h0) and s_seq_ev) |=> irq_pulse) else $error("irq missing for count zero");
   a_irq_count_bound: assert property (@(posedge clk) disable iff (!resetn)
      irq_pulse |-> $past(seq_cnt_r) == $past(seq_per_irq)) else $error("irq at wrong count");
   a_cnt_restart: assert property (@(posedge clk) disable iff (!resetn)
      (ctrl_wr || !conv_active) |=> seq_cnt_r == 4'h0) else $error("counter not restarted");
   a_unimpl_zero: assert property (@(posedge clk) disable iff (!resetn)
      (ctrl_r & ~ADCSQ_WMASK) == 16'h0000) else $error("unimplemented bit set");
   a_cal_ground: assert property (@(posedge clk) disable iff (!resetn)
      cal |-> inputs_to_ground && !input_switch_en) else $error("cal not grounding");
   a_cal_ch_zero: assert property (@(posedge clk) disable iff (!resetn)
      $past(cal) && cal |-> sample_ch == '0) else $error("channel leaked in cal");
   a_alt_off_first: assert property (@(posedge clk) disable iff (!resetn)
      !alt |=> mux_sel == ADCSQ_MUX_FIRST) else $error("second mux without alternate");
   a_alt_toggle: assert property (@(posedge clk) disable iff (!resetn)
      alt && conv_active && sample_done ##1 alt && conv_active |-> mux_sel != $past(mux_sel))
      else $error("mux did not alternate");
   a_ref_ext_both: assert property (@(posedge clk) disable iff (!resetn)
      ctrl_r[ADCSQ_REF_LSB +: 3] == 3'h3 |-> ref_select == ADCSQ_REF_BOTH) else $error("ref decode");

   //==========================================================
   // Interrupt pacing after a restart
   //==========================================================
   // The first sequence after a restart must not interrupt unless the code is zero
   a_irq_not_first: assert property (@(posedge clk) disable iff (!resetn)
      s_restart ##1 s_idle ##1 (s_seq_ev and (seq_per_irq != 4'h0)) |=> !irq_pulse)
      else $error("irq on first sequence after restart");
   a_irq_second: assert property (@(posedge clk) disable iff (!resetn)
      s_restart ##1 s_idle ##1 s_seq_ev ##1 s_idle ##1 (s_seq_ev and (seq_per_irq == 4'h1)) |=> irq_pulse)
      else $error("irq missing on second sequence");

   //==========================================================
   // Readback and reference decode
   //==========================================================
   // Checked at the read port as well, so a stray bit other than bit 7 in the read mux is caught
   a_unimpl_read: assert property (@(posedge clk) disable iff (!resetn)
      $past(reg_rd) && $past(reg_addr) == ADCSQ_OFF_CTRL |-> (reg_rdata & UNIMPL_MASK) == 16'h0000)
      else $error("unimplemented bit read as one");
   a_ref_ext_pos: assert property (@(posedge clk) disable iff (!resetn)
      ref_code == 3'h1 |-> ref_select == ADCSQ_REF_EXTP) else $error("ref decode positive");
   a_ref_ext_neg: assert property (@(posedge clk) disable iff (!resetn)
      ref_code == 3'h2 |-> ref_select == ADCSQ_REF_EXTN) else $error("ref decode negative");
   a_ref_internal: assert property (@(posedge clk) disable iff (!resetn)
      ref_code == 3'h0 || ref_code[2] |-> ref_select == ADCSQ_REF_INT) else $error("ref decode internal");

   //==========================================================
   // Calibration and channel routing
   //==========================================================
   a_cal_normal: assert property (@(posedge clk) disable iff (!resetn)
      !cal |-> !inputs_to_ground && input_switch_en) else $error("inputs grounded outside cal");
   a_cal_no_scan: assert property (@(posedge clk) disable iff (!resetn)
      cal |-> !scan_first_mux) else $error("scan active in cal");
   // Routing checks skip the edge after reset, where the channel register still holds zero
   a_scan_ch: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) && !$past(cal) && $past(scan) && $past(mux_r) == ADCSQ_MUX_FIRST
      |-> sample_ch == $past(scan_ch)) else $error("scan channel not routed");
   a_normal_ch: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) && !$past(cal) && !$past(scan) && $past(mux_r) == ADCSQ_MUX_FIRST
      |-> sample_ch == $past(first_mux_ch)) else $error("first mux channel not routed");
   a_second_ch: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) && !$past(cal) && $past(mux_r) == ADCSQ_MUX_SECOND
      |-> sample_ch == $past(second_mux_ch)) else $error("second mux channel not routed");
   a_alt_start_first: assert property (@(posedge clk) disable iff (!resetn)
      !conv_active |=> mux_sel == ADCSQ_MUX_FIRST) else $error("first sample not on first mux");
endmodule : adcsq_top

// ### test_adcsq_top.sv
`timescale 1ns/1ps
module test_adcsq_top;
   import adcsq_pkg::*;
   logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, conv_active = 0, sample_done = 0, seq_done = 0;
   logic [3:0] reg_addr = 4'h0, first_mux_ch = 4'h3, second_mux_ch = 4'h5, scan_ch = 4'h9, sample_ch;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
   logic [1:0] ref_select;
   logic offset_cal_enable, inputs_to_ground, input_switch_en, scan_first_mux, mux_sel, irq_pulse;
   int bad_count = 0, n_checks = 0;
   adcsq_top u_adcsq_top (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .conv_active, .sample_done, .seq_done, .first_mux_ch, .second_mux_ch, .scan_ch, .ref_select,
      .offset_cal_enable, .inputs_to_ground, .input_switch_en, .scan_first_mux, .mux_sel, .sample_ch,
      .irq_pulse);
   always #50 clk = ~clk;
   //==========================================
   // Check helper, bus and event drivers
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // Pulse one event line; returns after the edge that answers it
   task pulse(input bit seq);
      @(posedge clk);
      if (seq) seq_done <= 1'b1; else sample_done <= 1'b1;
      @(posedge clk);
      seq_done <= 1'b0; sample_done <= 1'b0;
      #1;
   endtask : pulse
   //==========================================
   // Scenarios
   task t_regs;
      rd(ADCSQ_OFF_CTRL); chk(d, 16'h0000);
      chk({14'h0, input_switch_en, mux_sel}, 16'h0002);
      wr(ADCSQ_OFF_CTRL, 16'hfffd); rd(ADCSQ_OFF_CTRL); chk(d & 16'hff7f, 16'hf43d);
      rd(4'h8); chk(d, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr(ADCSQ_OFF_CTRL, 16'(i) << 13);
         chk(16'(ref_select), i[2] ? 16'h0 : 16'({i[0], i[1]}));
      end
      $display("done regs");
   endtask : t_regs
   task t_cal;
      wr(ADCSQ_OFF_CTRL, 16'h1400); @(posedge clk); #1;
      chk({offset_cal_enable, inputs_to_ground, input_switch_en, scan_first_mux, sample_ch}, 16'h00c0);
      wr(ADCSQ_OFF_CTRL, 16'h0400);
      chk({offset_cal_enable, inputs_to_ground, input_switch_en, scan_first_mux}, 16'h0003);
      @(posedge clk);
      #1;
      chk(16'(sample_ch), 16'h0009);
      wr(ADCSQ_OFF_CTRL, 16'h0000); chk(16'(scan_first_mux), 16'h0);
      $display("done cal");
   endtask : t_cal
   task t_irq;
      @(posedge clk);
      conv_active <= 1'b1;
      wr(ADCSQ_OFF_CTRL, 16'h0004);
      pulse(1); chk(16'(irq_pulse), 16'h0);
      rd(ADCSQ_OFF_STAT); chk(d, 16'h0001);
      pulse(1); chk(16'(irq_pulse), 16'h1);
      pulse(1); wr(ADCSQ_OFF_CTRL, 16'h0004);
      pulse(1); chk(16'(irq_pulse), 16'h0);
      pulse(1); chk(16'(irq_pulse), 16'h1);
      wr(ADCSQ_OFF_CTRL, 16'h0000);
      pulse(1); chk(16'(irq_pulse), 16'h1);
      $display("done irq");
   endtask : t_irq
   task t_alt;
      wr(ADCSQ_OFF_CTRL, 16'h0001);
      pulse(0); @(posedge clk); #1;
      chk({mux_sel, sample_ch}, 16'h0015);
      pulse(0); @(posedge clk); #1;
      chk({mux_sel, sample_ch}, 16'h0003);
      wr(ADCSQ_OFF_CTRL, 16'h0000);
      pulse(0); @(posedge clk); #1;
      chk({mux_sel, sample_ch}, 16'h0003);
      @(posedge clk);
      conv_active <= 1'b0;
      $display("done alt");
   endtask : t_alt
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_cal();
      t_irq();
      t_alt();
      test_done();
   end
   initial begin
      #200000;
      bad_count++;
      test_done();
   end
endmodule : test_adcsq_top
